// >>> scc_pkg.sv
// Constants for the stop-mode clock control block.
// Assumes a single 40 MHz clock and an APB register port.
// Notes on behaviour
// (R1) Wait mode changes nothing; clocks and sources stay as in run mode.
// (R2) Stop mode is entered only on the core's stop request.
// (R3) In stop the RC clock stays on and power-on detection stays live.
// (R4) Low-voltage interrupt and reset units are disabled during stop.
// (R5) Autonomous periodic timer keeps running in stop mode.
// (R6) Loop clock and internal reference clock switch off in stop.
// (R7) Core, bus and debug clocks are stopped during stop.
// (R8) Pseudo stop if pseudo select and oscillator enable both set, else full.
// (R9) Full stop disables the external oscillator.
// (R10) Upper watchdog select 0: watchdog and tick counters halt in full stop.
// (R11) Wake from full stop, upper select 0: loop clock, reference selects.
// (R12) Upper watchdog select 1: watchdog clocked from the RC clock.
// (R13) Stop-clock disable set stops RC clock to watchdog in full stop.
// (R14) Bus from oscillator only when enabled, started and loop select 0.
// (R15) Loop clock stays running to qualify oscillator clock.
// (R16) Periodic output carries selected source, driven only when enabled.
// (R17) Sense select steers temperature or bandgap voltage to converter.
// (R18) Gated clocks start and stop on whole cycles without glitches.
package scc_pkg;
  localparam logic [11:0] SCC_CTRL_ADDR = 12'h000;
  localparam logic [11:0] SCC_STAT_ADDR = 12'h004;
  localparam int SCC_ADDR_W = 12;

  // Control register fields
  localparam int CTL_PSEUDO = 0;
  localparam int CTL_OSCEN = 1;
  localparam int CTL_PLL_CLOCK_SELECT = 2;
  localparam int CTL_WDSEL0 = 3;
  localparam int CTL_WDSEL1 = 4;
  localparam int CTL_TICKSEL = 5;
  localparam int CTL_WDSTOPDIS = 6;
  localparam int CTL_PERSRC = 7;
  localparam int CTL_PEREN = 8;
  localparam int CTL_SENSE = 9;
  localparam int CTL_W = 10;
  localparam logic [CTL_W-1:0] CTL_RESET = 10'h004;

  // Status register fields
  localparam int STA_OSCUP = 0;
  localparam int STA_STOP = 1;
  localparam int STA_PSEUDO = 2;
  localparam int STA_BUSOSC = 3;
  localparam int STA_W = 4;

  // Synchroniser depth for pin inputs
  localparam int SCC_SYNC_STAGES = 2;

  typedef enum logic [1:0] {
    SCC_RUN,
    SCC_FULL_STOP,
    SCC_PSEUDO_STOP
  } scc_mode_t;
endpackage : scc_pkg

// >>> scc_sync.sv
// Two-flop level synchroniser for pin inputs.
// Assumes the input is asynchronous to clk.
`timescale 1ns/1ps
module scc_sync #(
  parameter int STAGES = 2
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic asyncIn,
  output logic syncOut
);
  logic [STAGES-1:0] chain;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      chain <= '0;
    end else begin
      chain <= {chain[STAGES-2:0], asyncIn};
    end
  end

  assign syncOut = chain[STAGES-1];
endmodule : scc_sync

// >>> scc_stop_clock_control.sv
// Stop-mode clock control: gates core, bus and debug clocks, picks full or
// pseudo stop, steers watchdog and tick clocks, restores sources on wake.
// Assumes APB master on clk; stop request and wake-up come from logic on clk;
// the oscillator started flag comes from a pin.
`timescale 1ns/1ps
module scc_stop_clock_control
  import scc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [SCC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic stopRequest,
  input wire logic wakeRequest,
  input wire logic oscillatorStartedPin,
  input wire logic periodicTickClock,
  input wire logic periodicTickEvent,
  output logic coreClockEnable,
  output logic busClockEnable,
  output logic debugClockEnable,
  output logic busFromOscillator,
  output logic loopClockOn,
  output logic referenceClockOn,
  output logic rcClockOn,
  output logic externalOscillatorOn,
  output logic powerOnDetectOn,
  output logic lowVoltageIntOn,
  output logic lowVoltageResetOn,
  output logic periodicTimerOn,
  output logic watchdogRun,
  output logic watchdogFromRc,
  output logic tickRun,
  output logic periodicOut,
  output logic periodicOutEnable,
  output logic senseSourceSelect
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation
  logic oscStarted;

  scc_sync #(
    .STAGES(SCC_SYNC_STAGES)
  ) u_osc_sync (
    .clk(clk),
    .nrst(nrst),
    .asyncIn(oscillatorStartedPin),
    .syncOut(oscStarted)
  );

  ////////////////////////////////////////////////////////////////////////////
  // APB decode
  logic [CTL_W-1:0] ctrl;
  scc_mode_t mode;
  scc_mode_t next_mode;
  logic setupPhase;
  logic accessWrite;
  logic wakeFromFull;

  function automatic logic isMapped(input logic [SCC_ADDR_W-1:0] a);
    return (a == SCC_CTRL_ADDR) || (a == SCC_STAT_ADDR);
  endfunction : isMapped

  assign setupPhase = psel && !penable;
  assign accessWrite = psel && penable && pready && pwrite;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setupPhase;
      pslverr <= setupPhase && !isMapped(paddr);
      if (setupPhase && !pwrite && paddr == SCC_CTRL_ADDR) begin
        prdata <= {{(32-CTL_W){1'b0}}, ctrl};
      end else if (setupPhase && !pwrite && paddr == SCC_STAT_ADDR) begin
        prdata <= {{(32-STA_W){1'b0}}, busFromOscillator,
                   mode == SCC_PSEUDO_STOP, mode != SCC_RUN, oscStarted};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register; wake restore overrides a same-cycle write
  assign wakeFromFull = (mode == SCC_FULL_STOP) && wakeRequest;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl <= CTL_RESET;
    end else if (wakeFromFull && !ctrl[CTL_WDSEL1]) begin
      ctrl[CTL_PLL_CLOCK_SELECT] <= 1'b1; // R11
      ctrl[CTL_WDSEL0] <= 1'b0; // R11
      ctrl[CTL_TICKSEL] <= 1'b0; // R11
    end else if (accessWrite && paddr == SCC_CTRL_ADDR) begin
      ctrl <= pwdata[CTL_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode sequencing
  always_comb begin
    next_mode = mode;
    unique case (mode)
      SCC_RUN: begin
        if (stopRequest) begin // R2
          if (ctrl[CTL_PSEUDO] && ctrl[CTL_OSCEN]) begin // R8
            next_mode = SCC_PSEUDO_STOP;
          end else begin
            next_mode = SCC_FULL_STOP;
          end
        end
      end
      SCC_FULL_STOP, SCC_PSEUDO_STOP: begin
        if (wakeRequest) begin
          next_mode = SCC_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode <= SCC_RUN;
    end else begin
      mode <= next_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock gating and source outputs, all registered whole-cycle enables
  logic next_stopped;
  logic next_full;
  logic next_pll_clock_select;

  assign next_stopped = next_mode != SCC_RUN;
  assign next_full = next_mode == SCC_FULL_STOP;
  assign next_pll_clock_select = (wakeFromFull && !ctrl[CTL_WDSEL1]) ? 1'b1 :
                       ctrl[CTL_PLL_CLOCK_SELECT];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      coreClockEnable <= 1'b1;
      busClockEnable <= 1'b1;
      debugClockEnable <= 1'b1;
    end else begin
      // Wait mode has no input here; run settings hold outside stop
      coreClockEnable <= !next_stopped; // R7 R18 R1
      busClockEnable <= !next_stopped; // R7 R18
      debugClockEnable <= !next_stopped; // R7 R18
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      loopClockOn <= 1'b1;
      referenceClockOn <= 1'b1;
      rcClockOn <= 1'b1;
      externalOscillatorOn <= 1'b0;
      busFromOscillator <= 1'b0;
    end else begin
      loopClockOn <= !next_stopped; // R6 R15
      referenceClockOn <= !next_stopped; // R6
      rcClockOn <= 1'b1; // R3
      externalOscillatorOn <= ctrl[CTL_OSCEN] && !next_full; // R9
      busFromOscillator <= ctrl[CTL_OSCEN] && oscStarted
                           && !next_pll_clock_select && !next_stopped; // R14
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      powerOnDetectOn <= 1'b1;
      lowVoltageIntOn <= 1'b1;
      lowVoltageResetOn <= 1'b1;
      periodicTimerOn <= 1'b1;
    end else begin
      powerOnDetectOn <= 1'b1; // R3
      lowVoltageIntOn <= !next_stopped; // R4
      lowVoltageResetOn <= !next_stopped; // R4
      periodicTimerOn <= 1'b1; // R5
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      watchdogRun <= 1'b1;
      watchdogFromRc <= 1'b0;
      tickRun <= 1'b1;
    end else begin
      watchdogFromRc <= ctrl[CTL_WDSEL1]; // R12
      if (next_full && !ctrl[CTL_WDSEL1]) begin
        watchdogRun <= 1'b0; // R10
        tickRun <= 1'b0; // R10
      end else if (next_full) begin
        watchdogRun <= !ctrl[CTL_WDSTOPDIS]; // R13
        tickRun <= 1'b0;
      end else begin
        watchdogRun <= 1'b1;
        tickRun <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      periodicOut <= 1'b0;
      periodicOutEnable <= 1'b0;
      senseSourceSelect <= 1'b0;
    end else begin
      periodicOutEnable <= ctrl[CTL_PEREN]; // R16
      periodicOut <= ctrl[CTL_PEREN] && (ctrl[CTL_PERSRC] ?
                     periodicTickEvent : periodicTickClock); // R16
      senseSourceSelect <= ctrl[CTL_SENSE]; // R17
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_stop_entry_gates: // R2
    assert property (mode == SCC_RUN && stopRequest |=>
                     !coreClockEnable && !busClockEnable && !debugClockEnable)
      else $error("stop request did not gate clocks");

  a_no_spurious_stop: // R2
    assert property (mode == SCC_RUN && !stopRequest |=> mode == SCC_RUN)
      else $error("stop entered without request");

  a_pseudo_select: // R8
    assert property (mode == SCC_RUN && stopRequest && ctrl[CTL_PSEUDO]
                     && ctrl[CTL_OSCEN] |=> mode == SCC_PSEUDO_STOP)
      else $error("pseudo stop not selected");

  a_full_select: // R8
    assert property (mode == SCC_RUN && stopRequest
                     && !(ctrl[CTL_PSEUDO] && ctrl[CTL_OSCEN])
                     |=> mode == SCC_FULL_STOP)
      else $error("full stop not selected");

  a_full_osc_off: // R9
    assert property (mode == SCC_FULL_STOP && $past(mode) == SCC_FULL_STOP
                     |-> !externalOscillatorOn)
      else $error("oscillator on in full stop");

  a_stop_sources_off: // R6
    assert property ($rose(mode != SCC_RUN) |-> !loopClockOn
                     && !referenceClockOn && rcClockOn)
      else $error("sources not off in stop");

  a_stop_lv_off: // R4
    assert property (mode != SCC_RUN |-> !lowVoltageIntOn
                     && !lowVoltageResetOn && powerOnDetectOn)
      else $error("low voltage units active in stop");

  a_wd_halt_full: // R10
    assert property (mode == SCC_FULL_STOP && !ctrl[CTL_WDSEL1]
                     && $stable(mode) |-> !watchdogRun && !tickRun)
      else $error("watchdog runs in full stop");

  a_wake_restore: // R11
    assert property (wakeFromFull && !ctrl[CTL_WDSEL1] |=>
                     ctrl[CTL_PLL_CLOCK_SELECT] && !ctrl[CTL_WDSEL0]
                     && !ctrl[CTL_TICKSEL] && coreClockEnable)
      else $error("wake restore missing");

  a_bus_osc_gate: // R14
    assert property (busFromOscillator |-> $past(ctrl[CTL_OSCEN])
                     && $past(oscStarted) && loopClockOn)
      else $error("bus on oscillator too early");

  a_periodic_off: // R16
    assert property (!ctrl[CTL_PEREN] |=> !periodicOutEnable && !periodicOut)
      else $error("periodic output driven while disabled");

  a_apb_one_wait: // APB timing
    assert property (setupPhase |=> pready ##1 !pready)
      else $error("apb answer timing wrong");

  c_full_stop: cover property (mode == SCC_RUN ##1 mode == SCC_FULL_STOP
                               ##[1:20] mode == SCC_RUN);
  c_pseudo_stop: cover property (mode == SCC_PSEUDO_STOP ##1 wakeRequest);
  c_bus_osc: cover property ($rose(busFromOscillator));
  c_wd_rc_stop: cover property (mode == SCC_FULL_STOP && watchdogRun);

endmodule : scc_stop_clock_control

// >>> test_scc_stop_clock_control.sv
// Self-checking bench for the stop-mode clock control block.
// Assumes scc_pkg is compiled first; drives APB and stop/wake directly.
`timescale 1ns/1ps
module test_scc_stop_clock_control import scc_pkg::*;;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [SCC_ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = 32'h0;
  logic stopRequest = 1'b0;
  logic wakeRequest = 1'b0;
  logic oscillatorStartedPin = 1'b0;
  logic periodicTickClock = 1'b0;
  logic periodicTickEvent = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, coreClockEnable, busClockEnable, debugClockEnable;
  logic busFromOscillator, loopClockOn, referenceClockOn, rcClockOn;
  logic externalOscillatorOn, powerOnDetectOn, lowVoltageIntOn;
  logic lowVoltageResetOn, periodicTimerOn, watchdogRun, watchdogFromRc;
  logic tickRun, periodicOut, periodicOutEnable, senseSourceSelect;
  logic [31:0] rd;
  logic er;
  int fails = 0;
  int n_tests = 0;
  wire logic [31:0] gates = {24'h0, coreClockEnable, busClockEnable,
    debugClockEnable, loopClockOn, referenceClockOn, lowVoltageIntOn,
    lowVoltageResetOn, externalOscillatorOn};
  wire logic [31:0] wd = {26'h0, watchdogRun, tickRun, watchdogFromRc,
    rcClockOn, powerOnDetectOn, periodicTimerOn};
  wire logic [31:0] per = {29'h0, periodicOut, periodicOutEnable,
    senseSourceSelect};

  scc_stop_clock_control scc_stop_clock_control_i (
    .clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .stopRequest(stopRequest),
    .wakeRequest(wakeRequest), .oscillatorStartedPin(oscillatorStartedPin),
    .periodicTickClock(periodicTickClock),
    .periodicTickEvent(periodicTickEvent),
    .coreClockEnable(coreClockEnable), .busClockEnable(busClockEnable),
    .debugClockEnable(debugClockEnable),
    .busFromOscillator(busFromOscillator), .loopClockOn(loopClockOn),
    .referenceClockOn(referenceClockOn), .rcClockOn(rcClockOn),
    .externalOscillatorOn(externalOscillatorOn),
    .powerOnDetectOn(powerOnDetectOn), .lowVoltageIntOn(lowVoltageIntOn),
    .lowVoltageResetOn(lowVoltageResetOn),
    .periodicTimerOn(periodicTimerOn), .watchdogRun(watchdogRun),
    .watchdogFromRc(watchdogFromRc), .tickRun(tickRun),
    .periodicOut(periodicOut), .periodicOutEnable(periodicOutEnable),
    .senseSourceSelect(senseSourceSelect));

  always #12.5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pready", 32'h1, {31'h0, pready});
  endtask : apb

  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask : settle

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    settle();
  endtask : wr

  task automatic rdchk(input string nm, input logic [11:0] a,
                       input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask : rdchk

  // Pulse one cycle: wake when w is set, otherwise stop
  task automatic pulse(input logic w);
    @(posedge clk);
    if (w) wakeRequest <= 1'b1;
    else stopRequest <= 1'b1;
    @(posedge clk);
    wakeRequest <= 1'b0;
    stopRequest <= 1'b0;
    settle();
  endtask : pulse

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4000) @(posedge clk);
    fails++;
    report_and_stop();
  end

  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    settle();
    chk("reset gates", 32'hfe, gates);
    rdchk("ctrl reset", SCC_CTRL_ADDR, 32'h4);
    apb(1'b0, 12'h008, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, er});
    chk("unmapped data", 32'h0, rd);
    wr(SCC_STAT_ADDR, 32'hffffffff);
    rdchk("status ro", SCC_STAT_ADDR, 32'h0);
    // Oscillator as bus source
    wr(SCC_CTRL_ADDR, 32'h2);
    chk("bus osc early", 32'h0, {31'h0, busFromOscillator});
    @(posedge clk);
    oscillatorStartedPin <= 1'b1;
    settle();
    chk("bus osc", 32'h1, {31'h0, busFromOscillator});
    chk("loop qualifies", 32'h1, {31'h0, loopClockOn});
    rdchk("status osc", SCC_STAT_ADDR, 32'h9);
    pulse(1'b1);
    chk("wake in run", 32'hff, gates);
    // Full stop, upper watchdog select 0
    wr(SCC_CTRL_ADDR, 32'h2a);
    pulse(1'b0);
    chk("full gates", 32'h00, gates);
    chk("full wd", 32'h07, wd);
    rdchk("status full", SCC_STAT_ADDR, 32'h3);
    pulse(1'b1);
    chk("wake gates", 32'hff, gates);
    rdchk("ctrl restore", SCC_CTRL_ADDR, 32'h6);
    // Pseudo stop keeps oscillator and counters
    wr(SCC_CTRL_ADDR, 32'h3);
    pulse(1'b0);
    chk("pseudo gates", 32'h01, gates);
    chk("pseudo wd", 32'h37, wd);
    rdchk("status pseudo", SCC_STAT_ADDR, 32'h7);
    pulse(1'b1);
    rdchk("ctrl pseudo", SCC_CTRL_ADDR, 32'h3);
    // Full stop with RC watchdog, then stop-clock disable
    wr(SCC_CTRL_ADDR, 32'h11);
    pulse(1'b0);
    chk("rc wd run", 32'h2f, wd);
    pulse(1'b1);
    wr(SCC_CTRL_ADDR, 32'h50);
    pulse(1'b0);
    chk("rc wd stop", 32'h0f, wd);
    pulse(1'b1);
    chk("rc wd resume", 32'h1, {31'h0, watchdogRun});
    rdchk("ctrl kept", SCC_CTRL_ADDR, 32'h50);
    // Periodic output and sense select
    @(posedge clk);
    periodicTickClock <= 1'b1;
    wr(SCC_CTRL_ADDR, 32'h100);
    chk("per src0", 32'h6, per);
    @(posedge clk);
    periodicTickClock <= 1'b0;
    settle();
    chk("per src0 low", 32'h2, per);
    @(posedge clk);
    periodicTickEvent <= 1'b1;
    wr(SCC_CTRL_ADDR, 32'h380);
    chk("per src1", 32'h7, per);
    wr(SCC_CTRL_ADDR, 32'h080);
    chk("per off", 32'h0, per);
    report_and_stop();
  end
endmodule : test_scc_stop_clock_control
